// ==== design/dctf_core.v ====
/*
  Timing and flag core of a storage-tube display controller: data hold
  and path control registers, load, execute-delay and stroke timers,
  vector-continue state, ready and cursor flags, skip and interrupt.
  Assumes host bus levels and pulses arrive asynchronously on pins and
  that each I/O pulse is several hundred ns wide, far above two clocks.
*/
`timescale 1ns/1ps
`include "dctf_defs.vh"

module dctf_core
#(
  parameter LOAD_MC = `DCTF_LOAD_MC,
  parameter XDLY_MC = `DCTF_XDLY_MC,
  parameter STROKE_MC = `DCTF_STROKE_MC
)
(
  input wire clk,
  input wire rstn,
  input wire computerStart,
  input wire ioTransferInstruction,
  input wire loadExecutePulse,
  input wire dataLoadPulse,
  input wire pathLoadPulse,
  input wire readyClearPulse,
  input wire cursorClearPulse,
  input wire skipTestPulse,
  input wire [1:0] skipSelect,
  input wire executeSelectBit,
  input wire axisSelectBit,
  input wire [`DCTF_AC_W-1:0] accumulator,
  input wire cursorButton,
  input wire eraseButton,
  input wire comparatorHigh,
  output reg [`DCTF_DATA_W-1:0] dataHold,
  output reg pathSelectBit,
  output reg absoluteModeBit,
  output reg vectorLengthSelect,
  output reg readyFlag,
  output reg cursorFlag,
  output reg interruptRequest,
  output reg skipRequest,
  output reg transferXGate,
  output reg transferYGate,
  output reg absoluteGate,
  output reg executeDelayGate,
  output reg strokeGate,
  output reg vectorContinueGate
);

  ////////////////////////////////////////////////////////////////////////
  // Local constants

  localparam SYNC_W = 12 + `DCTF_AC_W;
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_LOAD = 5'h02;
  localparam [4:0] ST_XDLY = 5'h04;
  localparam [4:0] ST_STROKE = 5'h08;
  localparam [4:0] ST_VCONT = 5'h10;
  // Full-width copies first, then cut on purpose to the counter widths
  localparam [31:0] MC_NS_F = `DCTF_MC_NS;
  localparam [31:0] CLK_NS_F = `DCTF_CLK_NS;
  localparam [31:0] LOAD_F = LOAD_MC;
  localparam [31:0] XDLY_F = XDLY_MC;
  localparam [31:0] STROKE_F = STROKE_MC << `DCTF_STROKE_SHIFT;
  localparam [10:0] MC_NS = MC_NS_F[10:0];
  localparam [10:0] CLK_NS = CLK_NS_F[10:0];
  localparam [11:0] LOAD_CNT = LOAD_F[11:0];
  localparam [11:0] XDLY_CNT = XDLY_F[11:0];
  localparam [15:0] STROKE_UNITS = STROKE_F[15:0];
  localparam [15:0] STEP_LONG = 16'h0010;
  localparam [15:0] STEP_SHORT = 16'h0100;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops before any logic looks at a pin

  wire [SYNC_W-1:0] pinRaw;
  reg [SYNC_W-1:0] sync1_q;
  reg [SYNC_W-1:0] sync2_q;
  reg [SYNC_W-1:0] syncPrev_q;

  assign pinRaw = {computerStart, loadExecutePulse, dataLoadPulse,
                   pathLoadPulse, readyClearPulse, cursorClearPulse,
                   skipTestPulse, cursorButton, eraseButton, comparatorHigh,
                   executeSelectBit, axisSelectBit, accumulator};

  // First stage feeds only the second stage
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= {SYNC_W{1'b0}};
      sync2_q <= {SYNC_W{1'b0}};
      syncPrev_q <= {SYNC_W{1'b0}};
    end
    else
    begin
      sync1_q <= pinRaw;
      sync2_q <= sync1_q;
      syncPrev_q <= sync2_q;
    end
  end

  // Synchronised levels and rising edges
  wire [SYNC_W-1:0] rise = sync2_q & ~syncPrev_q;
  wire selected = ioTransferInstruction;
  wire startEv = rise[SYNC_W-1];
  wire ldExEv = rise[SYNC_W-2];
  wire dataEv = rise[SYNC_W-3];
  wire pathEv = rise[SYNC_W-4];
  wire rdyClrEv = rise[SYNC_W-5];
  wire curClrEv = rise[SYNC_W-6];
  wire skipLvl = sync2_q[SYNC_W-7];
  wire cursorEv = rise[SYNC_W-8];
  wire eraseEv = rise[SYNC_W-9];
  wire compLvl = sync2_q[SYNC_W-10];
  wire execSel = sync2_q[SYNC_W-11];
  wire axisSel = sync2_q[SYNC_W-12];
  wire [`DCTF_AC_W-1:0] acSync = sync2_q[`DCTF_AC_W-1:0];
  reg selSync1_q;
  reg selSync_q;
  reg [1:0] skipSel1_q;
  reg [1:0] skipSel_q;

  // Device select and skip code levels pass their own two flops
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      selSync1_q <= 1'b0;
      selSync_q <= 1'b0;
      skipSel1_q <= 2'h0;
      skipSel_q <= 2'h0;
    end
    else
    begin
      selSync1_q <= selected;
      selSync_q <= selSync1_q;
      skipSel1_q <= skipSelect;
      skipSel_q <= skipSel1_q;
    end
  end

  // Commands count only while this device is addressed
  wire cmdLoadExec = ldExEv & selSync_q;
  wire cmdData = (dataEv | ldExEv) & selSync_q;
  wire cmdPath = pathEv & selSync_q;
  wire cmdRdyClr = rdyClrEv & selSync_q;
  wire cmdCurClr = curClrEv & selSync_q;

  ////////////////////////////////////////////////////////////////////////
  // Host-loaded registers

  // Data hold taken from the accumulator low ten bits
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      dataHold <= `DCTF_DATA_RST;
    else if (cmdData)
      dataHold <= acSync[`DCTF_DATA_W-1:0];
  end

  // Persistent path configuration, also point plot select
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pathSelectBit <= `DCTF_BIT_RST;
      absoluteModeBit <= `DCTF_BIT_RST;
      vectorLengthSelect <= `DCTF_BIT_RST;
    end
    else if (cmdPath)
    begin
      pathSelectBit <= acSync[`DCTF_AC_PATH_BIT];
      absoluteModeBit <= acSync[`DCTF_AC_ABS_BIT];
      vectorLengthSelect <= acSync[`DCTF_AC_LEN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Machine cycle prescaler: 1.5 us from 8 ns clocks, exact on average

  reg [10:0] phase_q;
  reg [10:0] phase_d;
  reg mcTick;

  // Fractional accumulator avoids drift from the 187.5 clock ratio
  always @*
  begin
    mcTick = 1'b0;
    phase_d = phase_q + CLK_NS;
    if (phase_d >= MC_NS)
    begin
      phase_d = phase_d - MC_NS;
      mcTick = 1'b1;
    end
  end

  // Restarted by every load/execute command so each timer starts a full cycle
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      phase_q <= 11'h000;
    else if (cmdLoadExec)
      phase_q <= 11'h000;
    else
      phase_q <= phase_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Operation sequencer

  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [11:0] cnt_q;
  reg [11:0] cnt_d;
  reg [15:0] strokeLeft_q;
  reg [15:0] strokeLeft_d;
  reg axis_q;
  reg vcReq_q;
  reg point_q;
  reg opDone;

  // Point plot is decoded from the path select bit
  function isPointPlot;
    input pathBit;
    begin
      isPointPlot = ~pathBit;
    end
  endfunction

  // Step of the stroke budget per machine cycle
  function [15:0] strokeStep;
    input lenBit;
    begin
      strokeStep = lenBit ? STEP_SHORT : STEP_LONG;
    end
  endfunction

  // Next state and timer counts
  always @*
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    strokeLeft_d = strokeLeft_q;
    opDone = 1'b0;
    if (cmdLoadExec)
    begin
      // A new command cancels whatever was running
      cnt_d = 12'h000;
      strokeLeft_d = STROKE_UNITS;
      if (execSel)
        state_d = ST_XDLY;
      else
        state_d = ST_LOAD;
    end
    else
    begin
      case (state_q)
        ST_LOAD:
        begin
          if (mcTick)
            cnt_d = cnt_q + 12'h001;
          if (mcTick && cnt_d >= LOAD_CNT)
          begin
            state_d = ST_IDLE;
            opDone = 1'b1;
          end
        end
        ST_XDLY:
        begin
          if (mcTick)
            cnt_d = cnt_q + 12'h001;
          if (mcTick && cnt_d >= XDLY_CNT)
          begin
            if (vcReq_q)
            begin
              state_d = ST_VCONT;
              opDone = 1'b1;
            end
            else if (point_q)
            begin
              state_d = ST_IDLE;
              opDone = 1'b1;
            end
            else
              state_d = ST_STROKE;
          end
        end
        ST_STROKE:
        begin
          if (mcTick)
          begin
            if (strokeLeft_q > strokeStep(vectorLengthSelect))
              strokeLeft_d = strokeLeft_q - strokeStep(vectorLengthSelect);
            else
            begin
              strokeLeft_d = 16'h0000;
              state_d = ST_IDLE;
              opDone = 1'b1;
            end
          end
        end
        ST_VCONT:
        begin
          // Program times the stroke; a path reload ends it
          if (cmdPath)
            state_d = ST_IDLE;
        end
        default:
          state_d = ST_IDLE;
      endcase
    end
  end

  // Sequencer registers and per-command qualifiers
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 12'h000;
      strokeLeft_q <= 16'h0000;
      axis_q <= 1'b0;
      vcReq_q <= 1'b0;
      point_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      strokeLeft_q <= strokeLeft_d;
      if (cmdLoadExec)
      begin
        axis_q <= axisSel;
        vcReq_q <= execSel & acSync[`DCTF_AC_VC_BIT];
        point_q <= isPointPlot(pathSelectBit);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags: a set in the same cycle as a clear wins

  wire readySet = opDone | eraseEv;
  wire readyClr = cmdRdyClr | cmdLoadExec | startEv;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      readyFlag <= 1'b0;
      cursorFlag <= 1'b0;
    end
    else
    begin
      if (readySet)
        readyFlag <= 1'b1;
      else if (readyClr)
        readyFlag <= 1'b0;
      if (cursorEv)
        cursorFlag <= 1'b1;
      else if (cmdCurClr | startEv)
        cursorFlag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Skip and interrupt answers

  reg skipCond;

  // Skip source chosen by the instruction code
  always @*
  begin
    case (skipSel_q)
      `DCTF_SKIP_READY: skipCond = readyFlag;
      `DCTF_SKIP_CURSOR: skipCond = cursorFlag;
      `DCTF_SKIP_COMPARE: skipCond = compLvl;
      default: skipCond = ~state_q[0];
    endcase
  end

  // Skip held for the width of the synchronised skip pulse
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      skipRequest <= 1'b0;
      interruptRequest <= 1'b0;
    end
    else
    begin
      skipRequest <= skipLvl & selSync_q & skipCond;
      interruptRequest <= readyFlag | cursorFlag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gate pulses to the analog switches follow the timer states

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      transferXGate <= 1'b0;
      transferYGate <= 1'b0;
      absoluteGate <= 1'b0;
      executeDelayGate <= 1'b0;
      strokeGate <= 1'b0;
      vectorContinueGate <= 1'b0;
    end
    else
    begin
      transferXGate <= state_d[1] & ~axisPick(cmdLoadExec, axisSel, axis_q);
      transferYGate <= state_d[1] & axisPick(cmdLoadExec, axisSel, axis_q);
      absoluteGate <= state_d[1] & absoluteModeBit;
      executeDelayGate <= state_d[2];
      strokeGate <= state_d[3];
      vectorContinueGate <= state_d[4];
    end
  end

  // Axis for the gate in the cycle a command is taken
  function axisPick;
    input take;
    input fresh;
    input held;
    begin
      axisPick = take ? fresh : held;
    end
  endfunction

endmodule

// ==== design/dctf_defs.vh ====
/*
  Constants for the display controller timing and flag core: host bus
  field positions, register reset values and timing counts.
  Assumes a 125 MHz system clock and a host machine cycle of 1.5 us.
*/
`ifndef DCTF_DEFS_VH
`define DCTF_DEFS_VH

// Widths
`define DCTF_AC_W 12
`define DCTF_DATA_W 10

// Accumulator field positions
`define DCTF_AC_VC_BIT 7
`define DCTF_AC_PATH_BIT 0
`define DCTF_AC_ABS_BIT 1
`define DCTF_AC_LEN_BIT 2

// Skip condition select codes
`define DCTF_SKIP_READY 2'h0
`define DCTF_SKIP_CURSOR 2'h1
`define DCTF_SKIP_COMPARE 2'h2
`define DCTF_SKIP_BUSY 2'h3

// Reset values
`define DCTF_DATA_RST 10'h000
`define DCTF_BIT_RST 1'h0

// Timing: clock period and machine cycle in ns
`define DCTF_CLK_NS 8
`define DCTF_MC_NS 1500
// Nominal times in us, counts in machine cycles rounded to nearest
`define DCTF_LOAD_US 100
`define DCTF_XDLY_US 20
`define DCTF_LOAD_MC ((`DCTF_LOAD_US * 1000 + `DCTF_MC_NS / 2) / `DCTF_MC_NS)
`define DCTF_XDLY_MC ((`DCTF_XDLY_US * 1000 + `DCTF_MC_NS / 2) / `DCTF_MC_NS)
`define DCTF_STROKE_MC 2700
// Stroke is counted in sixteenths of a machine cycle
`define DCTF_STROKE_SHIFT 4

`endif

// ==== verification/dctf_core_props.sv ====
/*
  Port checker for dctf_core: flags, interrupt, skip and gate timing.
  Assumes host pulses several clocks wide and a bind to dctf_core.
*/
`timescale 1ns/1ps
`include "dctf_defs.vh"
module dctf_core_props
#(
  parameter LOAD_MC = 3,
  parameter XDLY_MC = 2,
  parameter STROKE_MC = 32
)
(
  input wire clk,
  input wire rstn,
  input wire computerStart,
  input wire ioTransferInstruction,
  input wire loadExecutePulse,
  input wire readyClearPulse,
  input wire cursorClearPulse,
  input wire skipTestPulse,
  input wire [`DCTF_AC_W-1:0] accumulator,
  input wire cursorButton,
  input wire eraseButton,
  input wire [`DCTF_DATA_W-1:0] dataHold,
  input wire readyFlag,
  input wire cursorFlag,
  input wire interruptRequest,
  input wire skipRequest,
  input wire strokeGate,
  input wire executeDelayGate,
  input wire transferXGate,
  input wire transferYGate,
  input wire vectorContinueGate
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt; sync delay allows a few clocks of slack
  AST_IRQ_SET: assert property ((readyFlag || cursorFlag) |=> interruptRequest)
    else $error("interrupt not raised");
  AST_IRQ_CLR: assert property (!(readyFlag || cursorFlag) [*2] |-> !interruptRequest)
    else $error("interrupt without flag");
  AST_START: assert property ($rose(computerStart)
    |-> ##[3:6] !(readyFlag || cursorFlag))
    else $error("start left a flag");
  AST_RCLR: assert property (ioTransferInstruction && $rose(readyClearPulse)
    |-> ##[3:6] !readyFlag)
    else $error("ready not cleared");
  AST_CCLR: assert property (ioTransferInstruction && $rose(cursorClearPulse)
    |-> ##[3:6] !cursorFlag)
    else $error("cursor not cleared");
  AST_CSET: assert property ($rose(cursorButton) |-> ##[3:6] cursorFlag)
    else $error("cursor not set");
  AST_ESET: assert property ($rose(eraseButton) |-> ##[3:6] readyFlag)
    else $error("erase did not set ready");
  ////////////////////////////////////////////////////////////////////////////
  // Data, skip and timer gates
  AST_DATA: assert property (ioTransferInstruction && $rose(loadExecutePulse)
    |-> ##[3:6] dataHold == accumulator[9:0])
    else $error("data hold not loaded");
  AST_SKIP: assert property (!skipTestPulse [*6] |-> !skipRequest)
    else $error("skip without strobe");
  AST_VC: assert property (vectorContinueGate |-> !strokeGate)
    else $error("stroke during continue");
  // A new command may cancel a stroke; that end sets no ready
  AST_STROKE: assert property ($fell(strokeGate) && !executeDelayGate
    && !transferXGate && !transferYGate |-> ##[0:2] readyFlag)
    else $error("stroke end without ready");
  cover property ($rose(strokeGate));
  cover property ($rose(vectorContinueGate));
  cover property ($rose(skipRequest));
endmodule
bind dctf_core dctf_core_props #(.LOAD_MC(LOAD_MC), .XDLY_MC(XDLY_MC), .STROKE_MC(STROKE_MC))
  chk_u (.clk(clk), .rstn(rstn), .computerStart(computerStart),
  .ioTransferInstruction(ioTransferInstruction), .loadExecutePulse(loadExecutePulse),
  .readyClearPulse(readyClearPulse), .cursorClearPulse(cursorClearPulse),
  .skipTestPulse(skipTestPulse), .accumulator(accumulator), .cursorButton(cursorButton),
  .eraseButton(eraseButton), .dataHold(dataHold), .readyFlag(readyFlag),
  .cursorFlag(cursorFlag), .interruptRequest(interruptRequest), .skipRequest(skipRequest),
  .strokeGate(strokeGate), .executeDelayGate(executeDelayGate),
  .transferXGate(transferXGate), .transferYGate(transferYGate),
  .vectorContinueGate(vectorContinueGate));

// ==== verification/dctf_host_model.sv ====
/*
  Host I/O bus model issuing transfer instructions and start.
  Assumes the device samples pulses that last several clocks.
*/
`timescale 1ns/1ps
module dctf_host_model
(
  input wire clk,
  input wire skipRequest,
  output reg computerStart = 1'b0,
  output reg ioTransferInstruction = 1'b0,
  output wire loadExecutePulse,
  output wire dataLoadPulse,
  output wire pathLoadPulse,
  output wire readyClearPulse,
  output wire cursorClearPulse,
  output wire skipTestPulse,
  output reg [1:0] skipSelect = 2'h0,
  output reg executeSelectBit = 1'b0,
  output reg axisSelectBit = 1'b0,
  output reg [11:0] accumulator = 12'h000
);
  reg [5:0] pulseQ = 6'h00;
  ////////////////////////////////////////////////////////////////////////////
  // Pulse lines fanned out by index
  assign {skipTestPulse, cursorClearPulse, readyClearPulse, pathLoadPulse, dataLoadPulse,
    loadExecutePulse} = pulseQ;
  // One transfer; qualifiers held for the whole pulse
  task io_transfer_instruction(input int k, input logic [11:0] ac, input logic x, input logic [1:0] s,
    output logic sk);
    @(posedge clk);
    ioTransferInstruction <= 1'b1;
    accumulator <= ac;
    executeSelectBit <= x;
    skipSelect <= s;
    axisSelectBit <= s[0];
    pulseQ[k] <= 1'b1;
    repeat (8) @(posedge clk);
    sk = skipRequest;
    pulseQ <= 6'h00;
    ioTransferInstruction <= 1'b0;
    accumulator <= ~ac; // Released bus has no pull
    executeSelectBit <= ~x;
    axisSelectBit <= ~s[0];
    repeat (8) @(posedge clk);
  endtask
  // Computer start pulse
  task start();
    @(posedge clk);
    computerStart <= 1'b1;
    repeat (8) @(posedge clk);
    computerStart <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ==== verification/display_controller_timing_flags_tb.sv ====
/*
  Self-checking bench for dctf_core driven through the host bus model.
  Assumes the shortened timing parameters chosen below.
*/
`timescale 1ns/1ps
`include "dctf_defs.vh"
module display_controller_timing_flags_tb;
  localparam int LMC = 3, XMC = 2, SMC = 32;
  logic clk = 1'b0, rstn = 1'b0, cursorButton = 1'b0, eraseButton = 1'b0, comparatorHigh = 1'b0;
  wire computerStart, ioTransferInstruction, loadExecutePulse, dataLoadPulse, pathLoadPulse;
  wire readyClearPulse, cursorClearPulse, skipTestPulse, executeSelectBit, axisSelectBit;
  wire [1:0] skipSelect;
  wire [11:0] accumulator;
  wire [9:0] dataHold;
  wire pathSelectBit, absoluteModeBit, vectorLengthSelect, readyFlag, cursorFlag;
  wire interruptRequest, skipRequest, transferXGate, transferYGate, absoluteGate;
  wire executeDelayGate, strokeGate, vectorContinueGate;
  int bad_count = 0, samples_checked = 0, n;
  int mcs[4] = '{XMC, XMC + SMC / 16, XMC + SMC, XMC};
  logic [11:0] cfg[4] = '{12'h000, 12'h005, 12'h001, 12'h001};
  logic sk, seen;
  dctf_core #(.LOAD_MC(LMC), .XDLY_MC(XMC), .STROKE_MC(SMC)) dut_u (.*);
  dctf_host_model host_u (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial
  begin
    forever #4 clk = ~clk;
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////
  task check(input string nm, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Clocks until ready, judged against a machine-cycle window; notes any stroke
  task tready(input string nm, input int mc);
    n = 0;
    seen = 1'b0;
    while (readyFlag !== 1'b1 && n < 20000)
    begin
      @(posedge clk);
      n++;
      seen = seen | strokeGate;
    end
    check(nm, 12'h001, (n >= mc * 187 - 120) && (n <= mc * 188 + 120));
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check("dataHold", 12'h000, dataHold);
    host_u.io_transfer_instruction(2, 12'h006, 1'b0, 2'h0, sk);
    check("config", 12'h003, {pathSelectBit, absoluteModeBit, vectorLengthSelect});
    host_u.io_transfer_instruction(0, 12'h2A5, 1'b0, 2'h0, sk);
    check("dataHold", 12'h2A5, dataHold);
    check("gates", 12'h005, {absoluteGate, transferYGate, transferXGate});
    host_u.io_transfer_instruction(5, 12'h000, 1'b0, `DCTF_SKIP_BUSY, sk);
    check("skipBusy", 12'h001, sk);
    tready("loadTime", LMC);
    repeat (2) @(posedge clk);
    check("irq", 12'h001, interruptRequest);
    host_u.io_transfer_instruction(5, 12'h000, 1'b0, `DCTF_SKIP_READY, sk);
    check("skipReady", 12'h001, sk);
    host_u.io_transfer_instruction(3, 12'h000, 1'b0, 2'h0, sk);
    check("cleared", 12'h000, {readyFlag, interruptRequest, transferXGate});
    $display("test load finished");
    for (int i = 0; i < 4; i++)
    begin
      host_u.io_transfer_instruction(2, cfg[i], 1'b0, 2'h0, sk);
      host_u.io_transfer_instruction(0, (i == 3) ? 12'h0D5 : 12'h155, 1'b1, 2'h0, sk);
      check("delayGate", 12'h001, executeDelayGate);
      tready("execTime", mcs[i]);
      check("strokeGate", i == 1 || i == 2, seen);
      repeat (2) @(posedge clk);
      check("vcGate", i == 3, vectorContinueGate);
      host_u.io_transfer_instruction(3, 12'h000, 1'b0, 2'h0, sk);
    end
    host_u.io_transfer_instruction(2, 12'h001, 1'b0, 2'h0, sk);
    check("vcEnd", 12'h000, vectorContinueGate);
    $display("test execute finished");
    host_u.io_transfer_instruction(0, 12'h011, 1'b0, 2'h1, sk);
    repeat (200) @(posedge clk);
    host_u.io_transfer_instruction(0, 12'h022, 1'b0, 2'h1, sk);
    check("yGate", 12'h002, {transferYGate, transferXGate});
    tready("restart", LMC);
    host_u.io_transfer_instruction(3, 12'h000, 1'b0, 2'h0, sk);
    repeat (LMC * 188) @(posedge clk);
    check("oneReady", 12'h000, readyFlag);
    host_u.io_transfer_instruction(1, 12'h3C3, 1'b0, 2'h0, sk);
    check("dataOnly", 12'h3C3, {readyFlag, transferXGate, dataHold});
    $display("test restart finished");
    cursorButton <= 1'b1;
    repeat (8) @(posedge clk);
    check("cursor", 12'h001, cursorFlag);
    host_u.io_transfer_instruction(5, 12'h000, 1'b0, `DCTF_SKIP_CURSOR, sk);
    check("skipCursor", 12'h001, sk);
    host_u.io_transfer_instruction(4, 12'h000, 1'b0, 2'h0, sk);
    check("cursorClr", 12'h000, cursorFlag);
    cursorButton <= 1'b0;
    eraseButton <= 1'b1;
    repeat (8) @(posedge clk);
    cursorButton <= 1'b1;
    repeat (8) @(posedge clk);
    check("bothFlags", 12'h003, {readyFlag, cursorFlag});
    comparatorHigh <= 1'b1;
    host_u.io_transfer_instruction(5, 12'h000, 1'b0, `DCTF_SKIP_COMPARE, sk);
    check("skipCompare", 12'h001, sk);
    host_u.start();
    check("startClr", 12'h000, {readyFlag, cursorFlag});
    $display("test flags finished");
    conclude();
  end
endmodule
